// ===== core/dip_consts.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   Definitions only
`ifndef DIP_CONSTS_SVH
`define DIP_CONSTS_SVH

// ************************
// Register byte offsets
// ************************
`define DIP_OFS_CTRL     8'h00
`define DIP_OFS_SYNC     8'h04
`define DIP_OFS_PLL      8'h08
`define DIP_OFS_DLL      8'h0C
`define DIP_OFS_STATUS   8'h10

// ************************
// Field positions
// ************************
`define DIP_CTRL_FMT     0
`define DIP_CTRL_REV     1
`define DIP_CTRL_SWAP    2
`define DIP_CTRL_DUP     3
`define DIP_CTRL_DIGEN   4
`define DIP_CTRL_INTERP  5
`define DIP_CTRL_FSM_LO  6
`define DIP_CTRL_FSM_HI  7
`define DIP_CTRL_OFS_LO  8
`define DIP_CTRL_OFS_HI  10
`define DIP_SYNC_SOFT    0
`define DIP_SYNC_GO      1
`define DIP_PLL_EN       0
`define DIP_PLL_SLEEP    1
`define DIP_PLL_RST      2
`define DIP_PLL_DIV2     3
`define DIP_PLL_M_LO     8
`define DIP_PLL_M_HI     15
`define DIP_PLL_N_LO     16
`define DIP_PLL_N_HI     19
`define DIP_DLL_EN       0
`define DIP_DLL_SLEEP    1
`define DIP_DLL_INV      2
`define DIP_DLL_RESTART  3
`define DIP_STAT_PLL     0
`define DIP_STAT_DLL     1
`define DIP_STAT_LVL_LO  4
`define DIP_STAT_LVL_HI  6

// ************************
// Reset values and timing
// ************************
`define DIP_RST_PLL_M    8'h01
`define DIP_RST_PLL_N    4'h1
`define DIP_FIFO_DEPTH   8
`define DIP_CLK_MHZ      200
`define DIP_LOCK_NS      1000
`define DIP_LOCK_CYCLES  ((`DIP_LOCK_NS * `DIP_CLK_MHZ) / 1000)

`endif

// ===== core/dip_pkg.sv
// Purpose: Shared types of the input path block
// Assumes: Constants live in dip_consts.svh
// Notes:   Types only
package dip_pkg;

  // ************************
  // Modes
  // ************************
  typedef enum logic {
    DIP_INTERP_X2,
    DIP_INTERP_X4
  } dip_interp_t;

  // Averaging or hold filter, combined with a mixer action
  typedef enum logic [1:0] {
    DIP_FS_AVG_PASS,
    DIP_FS_AVG_INVERT,
    DIP_FS_AVG_ALT,
    DIP_FS_HOLD_PASS
  } dip_fs_mode_t;

endpackage : dip_pkg

// ===== core/dip_loop_if.sv
// Purpose: Control and lock status between core and loop monitor
// Assumes: Single clock domain
// Notes:   One instance per loop
`timescale 1ns/1ps
interface dip_loop_if;
  logic enable;
  logic sleep;
  logic hold;
  logic restart;
  logic raw_lock;
  logic locked;

  modport ctrl (output enable, output sleep, output hold,
                output restart, output raw_lock, input locked);
  modport mon  (input enable, input sleep, input hold,
                input restart, input raw_lock, output locked);
endinterface : dip_loop_if

// ===== core/dip_loop_mon.sv
// Purpose: Qualifies a raw analog lock flag into a reported lock
// Assumes: raw_lock synchronous to pclk
// Notes:   Lock needs raw lock stable for LOCK_CYCLES
`timescale 1ns/1ps
`include "dip_consts.svh"
module dip_loop_mon #(
  parameter int LOCK_CYCLES = `DIP_LOCK_CYCLES
) (
  input  wire logic  pclk,
  input  wire logic  presetn,
  dip_loop_if.mon    lp
);
  import dip_pkg::*;

  typedef struct packed {
    logic [15:0] cnt;
    logic        locked;
  } dip_mon_state_t;

  dip_mon_state_t r_reg;
  dip_mon_state_t r_next;
  logic           active;

  // Loop runs only when enabled, awake and out of reset
  assign active = lp.enable && !lp.sleep && !lp.hold;

  // Acquisition counter; restart or loss drops the lock at once
  always_comb begin
    r_next = r_reg;
    if (!active || lp.restart || !lp.raw_lock) begin
      r_next.cnt    = 16'h0000;
      r_next.locked = 1'b0;
    end else if (r_reg.cnt == 16'(LOCK_CYCLES - 1)) begin
      r_next.locked = 1'b1;
    end else begin
      r_next.cnt = r_reg.cnt + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign lp.locked = r_reg.locked;

endmodule : dip_loop_mon

// ===== core/dip_core.sv
// Purpose: Input conditioning, FIFO, interpolation and loop control
// Assumes: Source data and sync synchronous to pclk
// Notes:   APB slave, zero wait states, one word per register
//
// How it works
// [RULE1] Input format: two's complement or offset binary
// [RULE2] Bus reversal mirrors the input word bit order
// [RULE3] Path swap exchanges streams A and B
// [RULE4] Duplication copies the converter A stream to converter B
// [RULE5] Sync places read pointer from -4 to +3 of write pointer
// [RULE6] Offset resets to zero and is reapplied at every sync
// [RULE7] Interpolation chain runs only while digital logic is enabled
// [RULE8] Interpolation ratio selects output samples per input sample
// [RULE9] One first-stage setting: filter and mixer, both channels
// [RULE10] First coarse mixer runs at half the output rate
// [RULE11] PLL enable cleared bypasses the PLL to the input clock
// [RULE12] PLL sleep puts the PLL into low-power state
// [RULE13] PLL reset holds the PLL; software toggles it to restart
// [RULE14] VCO doubling divides the VCO output by two
// [RULE15] Software sets M and N keeping the phase detector in range
// [RULE16] DLL enable cleared bypasses the DLL; source owns timing
// [RULE17] DLL sleep puts the DLL into low-power state
// [RULE18] DLL clock inversion inverts the internal DLL clock
// [RULE19] Status shows PLL lock
// [RULE20] Status shows DLL lock; restart re-runs DLL acquisition
// [RULE21] Software sync source ignores the external sync input
// [RULE22] Order is reversal, format, swap, then duplication
// [RULE23] Settings reset inactive; lock status reads unlocked
//
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`include "dip_consts.svh"
module dip_core #(
  parameter int W           = 16,
  parameter int LOCK_CYCLES = `DIP_LOCK_CYCLES
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic [W-1:0]  src_data_a,
  input  wire logic [W-1:0]  src_data_b,
  input  wire logic          src_valid,
  input  wire logic          ext_sync,
  input  wire logic          pll_lock_raw,
  input  wire logic          dll_lock_raw,
  output logic      [W-1:0]  conv_a,
  output logic      [W-1:0]  conv_b,
  output logic               pll_bypass,
  output logic               pll_sleep,
  output logic               pll_hold_rst,
  output logic               pll_vco_div2,
  output logic      [7:0]    pll_m_div,
  output logic      [3:0]    pll_n_div,
  output logic               dll_bypass,
  output logic               dll_sleep,
  output logic               dll_restart,
  output logic               dll_inv_clk
);
  import dip_pkg::*;

  localparam int DEPTH = `DIP_FIFO_DEPTH;
  localparam int AW    = $clog2(DEPTH);

  // ************************
  // State
  // ************************
  typedef struct packed {
    logic [31:0]                  prdata;
    logic                         pslverr;
    logic                         fmt_offset;
    logic                         reverse;
    logic                         swap;
    logic                         dup;
    logic                         dig_en;
    dip_interp_t                  interp;
    dip_fs_mode_t                 fs_mode;
    logic [2:0]                   fifo_ofs;
    logic                         sync_soft;
    logic                         soft_go;
    logic                         pll_en;
    logic                         pll_sleep;
    logic                         pll_rst;
    logic                         vco_div2;
    logic [7:0]                   pll_m;
    logic [3:0]                   pll_n;
    logic                         dll_en;
    logic                         dll_sleep;
    logic                         dll_inv;
    logic                         dll_restart;
    logic [DEPTH-1:0][2*W-1:0]    mem;
    logic [AW-1:0]                wr_ptr;
    logic [AW-1:0]                rd_ptr;
    logic [1:0]                   phase;
    logic                         mix_sign;
    logic [1:0][W-1:0]            in_cur;
    logic [1:0][W-1:0]            s1;
    logic [1:0][W-1:0]            s1_prev;
    logic [1:0][W-1:0]            out;
  } dip_core_state_t;

  dip_core_state_t   r_reg;
  dip_core_state_t   r_next;
  logic [1:0][W-1:0] cond;
  logic [1:0][W-1:0] fifo_out;
  logic [1:0][W-1:0] filt;
  logic              addr_hit;
  logic              wr_en;
  logic              sync_evt;
  logic              rd_tick;
  logic              mix_neg;
  logic              pll_locked;
  logic              dll_locked;
  logic [AW-1:0]     level;

  // ************************
  // Helpers
  // ************************
  // Mirror bit order of one word
  function automatic logic [W-1:0] dip_mirror(input logic [W-1:0] x);
    logic [W-1:0] y;
    y = '0;
    for (int i = 0; i < W; i++) begin
      y[i] = x[W-1-i];
    end
    return y;
  endfunction : dip_mirror

  // Rounded-down mean of two signed samples, no overflow
  function automatic logic [W-1:0] dip_avg(input logic [W-1:0] x,
                                           input logic [W-1:0] y);
    logic [W:0] s;
    s = {x[W-1], x} + {y[W-1], y};
    return s[W:1];
  endfunction : dip_avg

  // Mixer action: pass or negate
  function automatic logic [W-1:0] dip_mix(input logic [W-1:0] x,
                                           input logic         neg);
    logic [W-1:0] y;
    y = neg ? (~x + {{(W-1){1'b0}}, 1'b1}) : x;
    return y;
  endfunction : dip_mix

  // ************************
  // Loop monitors
  // ************************
  dip_loop_if pll_if ();
  dip_loop_if dll_if ();

  assign pll_if.enable   = r_reg.pll_en;
  assign pll_if.sleep    = r_reg.pll_sleep;
  assign pll_if.hold     = r_reg.pll_rst;            // [RULE13]
  assign pll_if.restart  = 1'b0;
  assign pll_if.raw_lock = pll_lock_raw;
  assign pll_locked      = pll_if.locked;            // [RULE19]

  assign dll_if.enable   = r_reg.dll_en;
  assign dll_if.sleep    = r_reg.dll_sleep;
  assign dll_if.hold     = 1'b0;
  assign dll_if.restart  = r_reg.dll_restart;        // [RULE20]
  assign dll_if.raw_lock = dll_lock_raw;
  assign dll_locked      = dll_if.locked;            // [RULE20]

  dip_loop_mon #(.LOCK_CYCLES(LOCK_CYCLES)) u_pll_mon (
    .pclk    (pclk),
    .presetn (presetn),
    .lp      (pll_if.mon)
  );

  dip_loop_mon #(.LOCK_CYCLES(LOCK_CYCLES)) u_dll_mon (
    .pclk    (pclk),
    .presetn (presetn),
    .lp      (dll_if.mon)
  );

  // ************************
  // Input conditioning
  // ************************
  // Fixed order: mirror, format, swap, duplicate
  always_comb begin
    logic [1:0][W-1:0] t;
    t[0] = src_data_a;
    t[1] = src_data_b;
    for (int c = 0; c < 2; c++) begin
      if (r_reg.reverse) begin
        t[c] = dip_mirror(t[c]);                     // [RULE2] [RULE22]
      end
      if (r_reg.fmt_offset) begin
        t[c][W-1] = ~t[c][W-1];                      // [RULE1] [RULE22]
      end
    end
    cond = t;
    if (r_reg.swap) begin
      cond[0] = t[1];                                // [RULE3] [RULE22]
      cond[1] = t[0];
    end
    if (r_reg.dup) begin
      cond[1] = cond[0];                             // [RULE4] [RULE22]
    end
  end

  // ************************
  // Decode and datapath terms
  // ************************
  assign addr_hit = (paddr == `DIP_OFS_CTRL) || (paddr == `DIP_OFS_SYNC)
                 || (paddr == `DIP_OFS_PLL)  || (paddr == `DIP_OFS_DLL)
                 || (paddr == `DIP_OFS_STATUS);
  assign wr_en    = psel && penable && pwrite && addr_hit;
  // Soft source masks the pins completely
  assign sync_evt = r_reg.sync_soft ? r_reg.soft_go : ext_sync; // [RULE21]
  assign fifo_out = r_reg.mem[r_reg.rd_ptr];
  assign level    = r_reg.wr_ptr - r_reg.rd_ptr;
  // Input rate: every 2nd or 4th output cycle, every cycle when off
  assign rd_tick  = !r_reg.dig_en ? 1'b1 :
                    (r_reg.interp == DIP_INTERP_X2) ? !r_reg.phase[0] :
                    (r_reg.phase == 2'b00);          // [RULE8]
  assign mix_neg  = (r_reg.fs_mode == DIP_FS_AVG_INVERT) ||
                    ((r_reg.fs_mode == DIP_FS_AVG_ALT) && r_reg.mix_sign);

  // First filter output ahead of the mixer, both channels alike
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      if (r_reg.interp == DIP_INTERP_X2) begin
        filt[c] = fifo_out[c];
      end else if (r_reg.phase == 2'b00) begin
        filt[c] = (r_reg.fs_mode == DIP_FS_HOLD_PASS) ? r_reg.in_cur[c]
                  : dip_avg(r_reg.in_cur[c], fifo_out[c]);  // [RULE9]
      end else begin
        filt[c] = r_reg.in_cur[c];
      end
    end
  end

  // ************************
  // Next state
  // ************************
  always_comb begin
    r_next             = r_reg;
    r_next.soft_go     = 1'b0;
    r_next.dll_restart = 1'b0;

    // Setup phase latches read data so it comes from flops
    if (psel && !penable) begin
      r_next.pslverr = !addr_hit;
      r_next.prdata  = 32'h0000_0000;
      unique case (paddr)
        `DIP_OFS_CTRL: begin
          r_next.prdata[`DIP_CTRL_FMT]   = r_reg.fmt_offset;
          r_next.prdata[`DIP_CTRL_REV]   = r_reg.reverse;
          r_next.prdata[`DIP_CTRL_SWAP]  = r_reg.swap;
          r_next.prdata[`DIP_CTRL_DUP]   = r_reg.dup;
          r_next.prdata[`DIP_CTRL_DIGEN] = r_reg.dig_en;
          r_next.prdata[`DIP_CTRL_INTERP] = r_reg.interp;
          r_next.prdata[`DIP_CTRL_FSM_HI:`DIP_CTRL_FSM_LO] = r_reg.fs_mode;
          r_next.prdata[`DIP_CTRL_OFS_HI:`DIP_CTRL_OFS_LO] = r_reg.fifo_ofs;
        end
        `DIP_OFS_SYNC: begin
          r_next.prdata[`DIP_SYNC_SOFT] = r_reg.sync_soft;
        end
        `DIP_OFS_PLL: begin
          r_next.prdata[`DIP_PLL_EN]    = r_reg.pll_en;
          r_next.prdata[`DIP_PLL_SLEEP] = r_reg.pll_sleep;
          r_next.prdata[`DIP_PLL_RST]   = r_reg.pll_rst;
          r_next.prdata[`DIP_PLL_DIV2]  = r_reg.vco_div2;
          r_next.prdata[`DIP_PLL_M_HI:`DIP_PLL_M_LO] = r_reg.pll_m;
          r_next.prdata[`DIP_PLL_N_HI:`DIP_PLL_N_LO] = r_reg.pll_n;
        end
        `DIP_OFS_DLL: begin
          r_next.prdata[`DIP_DLL_EN]    = r_reg.dll_en;
          r_next.prdata[`DIP_DLL_SLEEP] = r_reg.dll_sleep;
          r_next.prdata[`DIP_DLL_INV]   = r_reg.dll_inv;
        end
        `DIP_OFS_STATUS: begin
          r_next.prdata[`DIP_STAT_PLL] = pll_locked;          // [RULE19]
          r_next.prdata[`DIP_STAT_DLL] = dll_locked;          // [RULE20]
          r_next.prdata[`DIP_STAT_LVL_HI:`DIP_STAT_LVL_LO] = level;
        end
        default: begin
          r_next.prdata = 32'h0000_0000;
        end
      endcase
    end

    // Access phase writes; status register is read only
    if (wr_en) begin
      unique case (paddr)
        `DIP_OFS_CTRL: begin
          r_next.fmt_offset = pwdata[`DIP_CTRL_FMT];
          r_next.reverse    = pwdata[`DIP_CTRL_REV];
          r_next.swap       = pwdata[`DIP_CTRL_SWAP];
          r_next.dup        = pwdata[`DIP_CTRL_DUP];
          r_next.dig_en     = pwdata[`DIP_CTRL_DIGEN];
          r_next.interp     = dip_interp_t'(pwdata[`DIP_CTRL_INTERP]);
          r_next.fs_mode    = dip_fs_mode_t'(
                              pwdata[`DIP_CTRL_FSM_HI:`DIP_CTRL_FSM_LO]);
          r_next.fifo_ofs   = pwdata[`DIP_CTRL_OFS_HI:`DIP_CTRL_OFS_LO];
        end
        `DIP_OFS_SYNC: begin
          r_next.sync_soft = pwdata[`DIP_SYNC_SOFT];
          r_next.soft_go   = pwdata[`DIP_SYNC_GO];
        end
        `DIP_OFS_PLL: begin
          r_next.pll_en    = pwdata[`DIP_PLL_EN];             // [RULE11]
          r_next.pll_sleep = pwdata[`DIP_PLL_SLEEP];          // [RULE12]
          r_next.pll_rst   = pwdata[`DIP_PLL_RST];            // [RULE13]
          r_next.vco_div2  = pwdata[`DIP_PLL_DIV2];           // [RULE14]
          r_next.pll_m     = pwdata[`DIP_PLL_M_HI:`DIP_PLL_M_LO];
          r_next.pll_n     = pwdata[`DIP_PLL_N_HI:`DIP_PLL_N_LO];
        end
        `DIP_OFS_DLL: begin
          r_next.dll_en      = pwdata[`DIP_DLL_EN];           // [RULE16]
          r_next.dll_sleep   = pwdata[`DIP_DLL_SLEEP];        // [RULE17]
          r_next.dll_inv     = pwdata[`DIP_DLL_INV];          // [RULE18]
          r_next.dll_restart = pwdata[`DIP_DLL_RESTART];      // [RULE20]
        end
        default: begin
          r_next.soft_go = 1'b0;
        end
      endcase
    end

    // FIFO write side runs at the source rate
    if (src_valid) begin
      r_next.mem[r_reg.wr_ptr] = cond;
      r_next.wr_ptr            = r_reg.wr_ptr + 1'b1;
    end

    // Read side; sync wins over the normal advance
    if (sync_evt) begin
      r_next.rd_ptr = r_reg.wr_ptr + r_reg.fifo_ofs;  // [RULE5] [RULE6]
    end else if (rd_tick) begin
      r_next.rd_ptr = r_reg.rd_ptr + 1'b1;
    end

    // Chain frozen when disabled; converters get FIFO words raw
    if (!r_reg.dig_en) begin
      r_next.phase = 2'b00;                                   // [RULE7]
      r_next.out   = fifo_out;
    end else begin
      r_next.phase = r_reg.phase + 2'b01;
      if (!r_reg.phase[0]) begin
        // Half-rate tick: first filter and mixer update
        for (int c = 0; c < 2; c++) begin
          r_next.s1[c] = dip_mix(filt[c], mix_neg);   // [RULE9] [RULE10]
        end
        r_next.s1_prev  = r_reg.s1;
        r_next.out      = r_reg.s1;
        r_next.mix_sign = !r_reg.mix_sign;                    // [RULE10]
        if (r_reg.interp == DIP_INTERP_X4 && r_reg.phase == 2'b00) begin
          r_next.in_cur = fifo_out;                           // [RULE8]
        end
      end else begin
        // Second filter inserts the midpoint at full rate
        for (int c = 0; c < 2; c++) begin
          r_next.out[c] = dip_avg(r_reg.s1_prev[c], r_reg.s1[c]);
        end
      end
    end
  end

  // ************************
  // Registers
  // ************************
  // Everything resets to zero except M and N, which load 1; lock flags come up unlocked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg       <= '0;                                      // [RULE23]
      r_reg.pll_m <= `DIP_RST_PLL_M;                          // [RULE15]
      r_reg.pll_n <= `DIP_RST_PLL_N;                          // [RULE15]
    end else begin
      r_reg <= r_next;
    end
  end

  // ************************
  // Outputs
  // ************************
  // Zero wait states; error only on an unmapped address
  assign pready       = 1'b1;
  assign pslverr      = r_reg.pslverr && psel && penable;
  assign prdata       = r_reg.prdata;
  assign conv_a       = r_reg.out[0];
  assign conv_b       = r_reg.out[1];
  // Clock mux selects input_reference_clock when bypassed
  assign pll_bypass   = !r_reg.pll_en;                        // [RULE11]
  assign pll_sleep    = r_reg.pll_sleep;                      // [RULE12]
  assign pll_hold_rst = r_reg.pll_rst;                        // [RULE13]
  assign pll_vco_div2 = r_reg.vco_div2;                       // [RULE14]
  // No range check on M and N: phase detector limit is software's job
  assign pll_m_div    = r_reg.pll_m;
  assign pll_n_div    = r_reg.pll_n;
  assign dll_bypass   = !r_reg.dll_en;                        // [RULE16]
  assign dll_sleep    = r_reg.dll_sleep;                      // [RULE17]
  assign dll_restart  = r_reg.dll_restart;                    // [RULE20]
  assign dll_inv_clk  = r_reg.dll_inv;                        // [RULE18]

endmodule : dip_core

// ===== tb/dip_src_model.sv
// Purpose: Parallel word source in front of the input path block
// Assumes: Words launched just after the rising edge
// Notes:   Idle lanes toggle so stale data never passes as valid
`timescale 1ns/1ps
module dip_src_model #(
  parameter int W = 16
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         run,
  input  wire logic [W-1:0] word_a,
  input  wire logic [W-1:0] word_b,
  output logic              src_valid,
  output logic      [W-1:0] src_data_a,
  output logic      [W-1:0] src_data_b
);
  // Clean synchronous launch, since capture timing is ours
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_valid  <= 1'b0;
      src_data_a <= '0;
      src_data_b <= '0;
    end else begin
      src_valid  <= run;
      src_data_a <= run ? word_a : ~src_data_a;
      src_data_b <= run ? word_b : ~src_data_b;
    end
  end
endmodule : dip_src_model

// ===== tb/dip_core_sva.sv
// Purpose: Port checks of the input path block
// Assumes: One clock, reset low disables all checks
// Notes:   Bound to dip_core below
`timescale 1ns/1ps
`include "dip_consts.svh"
module dip_core_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pll_bypass,
  input wire logic        pll_sleep,
  input wire logic [7:0]  pll_m_div,
  input wire logic        dll_bypass,
  input wire logic        dll_inv_clk,
  input wire logic        dll_restart
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Register writes as seen at the access edge
  wire logic acc    = psel && penable && pwrite;
  wire logic wr_pll = acc && (paddr == `DIP_OFS_PLL);
  wire logic wr_dll = acc && (paddr == `DIP_OFS_DLL);
  pll_bypass_a: assert property (
    wr_pll |=> pll_bypass == !$past(pwdata[0])) else $error("pll bypass");
  pll_sleep_a: assert property (
    wr_pll |=> pll_sleep == $past(pwdata[1])) else $error("pll sleep");
  m_div_load_a: assert property (
    wr_pll |=> pll_m_div == $past(pwdata[15:8])) else $error("m load");
  m_div_hold_a: assert property (
    !wr_pll |=> $stable(pll_m_div)) else $error("m changed");
  dll_bypass_a: assert property (
    wr_dll |=> dll_bypass == !$past(pwdata[0])) else $error("dll bypass");
  dll_inv_a: assert property (
    wr_dll |=> dll_inv_clk == $past(pwdata[2])) else $error("dll inv");
  restart_cause_a: assert property (
    wr_dll && pwdata[3] |=> dll_restart) else $error("no restart");
  restart_only_a: assert property (
    dll_restart |-> $past(wr_dll) && $past(pwdata[3]) ##1 !dll_restart)
    else $error("stray restart");
endmodule : dip_core_sva
bind dip_core dip_core_sva u_dip_core_sva (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pll_bypass,
  .pll_sleep, .pll_m_div, .dll_bypass, .dll_inv_clk, .dll_restart);

// ===== tb/tb_dip_core.sv
// Purpose: Self-checking bench of the input path block
// Assumes: Lock qualify shortened to 4 cycles
// Notes:   Constant source words make FIFO phase irrelevant
`timescale 1ns/1ps
`include "dip_consts.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected t=%0t got=%h exp=%h", $time, g, e); end end
module tb_dip_core;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = '0, pll_m_div;
  logic [31:0] pwdata = '0, prdata, rd;
  logic        pready, pslverr, slv, run = 0, ext_sync = 0, src_valid;
  logic        pll_lock_raw = 0, dll_lock_raw = 0, pll_sleep, pll_bypass;
  logic [15:0] wa = 16'h0001, wb = 16'h8002, src_data_a, src_data_b;
  logic [15:0] conv_a, conv_b;
  logic        pll_hold_rst, pll_vco_div2, dll_bypass, dll_sleep;
  logic        dll_restart, dll_inv_clk;
  logic [3:0]  pll_n_div;
  int          err_total = 0, tests_run = 0;
  always #2.5 pclk = ~pclk;
  dip_core #(.W(16), .LOCK_CYCLES(4)) u_dip_core (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .src_data_a, .src_data_b, .src_valid, .ext_sync, .pll_lock_raw,
    .dll_lock_raw, .conv_a, .conv_b, .pll_bypass, .pll_sleep, .pll_hold_rst,
    .pll_vco_div2, .pll_m_div, .pll_n_div, .dll_bypass, .dll_sleep,
    .dll_restart, .dll_inv_clk);
  dip_src_model #(.W(16)) u_dip_src_model (.pclk, .presetn, .run,
    .word_a(wa), .word_b(wb), .src_valid, .src_data_a, .src_data_b);
  // ************************
  // Bus and timing helpers
  // ************************
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask : idle
  // Request held until the pready edge; answer taken there
  task automatic apb(input logic w, logic [7:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic pulse;
    @(posedge pclk);
    ext_sync <= 1'b1;
    @(posedge pclk);
    ext_sync <= 1'b0;
  endtask : pulse
  task automatic t_reset;
    apb(1'b0, `DIP_OFS_PLL, 32'h0);
    `CHK(rd, 32'h0001_0100)
    `CHK({pll_bypass, dll_bypass}, 2'h3)
    apb(1'b0, `DIP_OFS_CTRL, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, 8'h40, 32'h0);
    `CHK(slv, 1'b1)
  endtask : t_reset
  // Conditioning cases; mixed ones show the order
  task automatic t_cond;
    logic [3:0]  c [7] = '{4'h0, 4'h2, 4'h1, 4'h3, 4'h4, 4'h8, 4'hC};
    logic [31:0] e [7] = '{32'h0001_8002, 32'h8000_4001, 32'h8001_0002,
      32'h0000_C001, 32'h8002_0001, 32'h0001_0001, 32'h8002_8002};
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, `DIP_OFS_CTRL, {28'h0, c[i]});
      idle(20);
      `CHK({conv_a, conv_b}, e[i])
    end
  endtask : t_cond
  // Steady input stays steady; alternating mixer sums to zero
  task automatic t_interp;
    logic [7:0]  c [4] = '{8'h10, 8'h50, 8'h30, 8'hF0};
    logic [15:0] e [4] = '{16'h0010, 16'hFFF0, 16'h0010, 16'h0010};
    logic [15:0] s = '0, x = '0;
    wa <= 16'h0010;
    wb <= 16'h0010;
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `DIP_OFS_CTRL, {24'h0, c[i]});
      idle(24);
      repeat (4) begin
        @(posedge pclk);
        `CHK({conv_a, conv_b}, {e[i], e[i]})
      end
    end
    apb(1'b1, `DIP_OFS_CTRL, 32'h90);
    idle(24);
    repeat (4) begin
      @(posedge pclk);
      s = s + conv_a;
      x = x | conv_b;
    end
    `CHK({s, x}, 32'h0000_FFF0)
  endtask : t_interp
  // Level differences cancel pointer latency
  task automatic t_sync;
    logic [2:0] base;
    apb(1'b1, `DIP_OFS_CTRL, 32'h0);
    pulse();
    apb(1'b0, `DIP_OFS_STATUS, 32'h0);
    base = rd[6:4];
    apb(1'b1, `DIP_OFS_CTRL, 32'h400);
    pulse();
    apb(1'b0, `DIP_OFS_STATUS, 32'h0);
    `CHK(rd[6:4], base + 3'h4)
    apb(1'b1, `DIP_OFS_SYNC, 32'h1);
    apb(1'b1, `DIP_OFS_CTRL, 32'h300);
    pulse();
    apb(1'b0, `DIP_OFS_STATUS, 32'h0);
    `CHK(rd[6:4], base + 3'h4)
    apb(1'b1, `DIP_OFS_SYNC, 32'h3);
    idle(2);
    apb(1'b0, `DIP_OFS_STATUS, 32'h0);
    `CHK(rd[6:4], base - 3'h3)
  endtask : t_sync
  task automatic t_loops;
    apb(1'b1, `DIP_OFS_PLL, 32'h0007_A50E); // N kept low
    idle(1);
    `CHK({pll_bypass, pll_sleep, pll_hold_rst, pll_vco_div2}, 4'hF)
    `CHK({pll_n_div, pll_m_div}, 12'h7A5)
    pll_lock_raw <= 1'b1;
    dll_lock_raw <= 1'b1;
    apb(1'b1, `DIP_OFS_PLL, 32'h0007_A501);
    apb(1'b1, `DIP_OFS_DLL, 32'h1);
    idle(10);
    apb(1'b0, `DIP_OFS_STATUS, 32'h0);
    `CHK(rd[1:0], 2'h3)
    apb(1'b1, `DIP_OFS_PLL, 32'h0007_A505);
    apb(1'b1, `DIP_OFS_DLL, 32'h9);
    apb(1'b0, `DIP_OFS_STATUS, 32'h0);
    `CHK(rd[1:0], 2'h0)
    apb(1'b1, `DIP_OFS_DLL, 32'h6);
    idle(1);
    `CHK({dll_bypass, dll_sleep, dll_inv_clk}, 3'h7)
  endtask : t_loops
  task automatic complete_run;
    $display("errors=%0d checks=%0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run
  // Main sequence
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    run <= 1'b1;
    t_reset();
    t_cond();
    t_interp();
    t_sync();
    t_loops();
    complete_run();
  end
  // Watchdog far beyond the roughly 400 cycles the tasks need
  initial begin
    #50000;
    err_total++;
    complete_run();
  end
endmodule : tb_dip_core
